// ### emp_host.sv
// Host side of the serial link; the clock is parked low between frames.
module emp_host (
    input wire clk,
    input wire sdo,
    input wire sdo_oe_n,
    output logic cs_n,
    output logic sclk,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n = 1'h1;
        sclk = 1'h0;
        sdi = 1'h0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One frame of cut bits; a released output reads as unknown.
    task automatic xfer(input logic tw, input logic [23:0] tx, input int h, c,
        output logic [15:0] rx);
        step(1);
        cs_n = 1'h0;
        for (int i = 23; i >= 24 - c; i--) begin
            sdi = tx[i];
            step(h);
            sclk = 1'h1;
            step(h);
            if (i < 16) rx[i] = sdo_oe_n ? 1'hx : sdo;
            sclk = 1'h0;
        end
        sdi = ~sdi;
        step(h);
        cs_n = !tw;
    endtask
endmodule

// ### emp_map.vh
`ifndef EMP_MAP_VH
`define EMP_MAP_VH
// Serial frame layout: 1 direction bit, 7 address bits, 16 data bits.
`define EMP_FRAME_BITS 24
`define EMP_ADDR_BITS 7
`define EMP_DATA_BITS 16
// Register addresses; the pin logic decodes only the mode address.
`define EMP_ADDR_STATUS 7'h01
`define EMP_ADDR_MODE 7'h2B
// Field positions inside the metering mode register.
`define EMP_MODE_ZX_LSB 2
`define EMP_MODE_ZX_MSB 3
`define EMP_MODE_LINE_SELECT_BIT_BIT 4
// Reset values.
`define EMP_MODE_RESET 16'h0000
// Zero-crossing selector encodings.
`define EMP_ZX_POS 2'h0
`define EMP_ZX_NEG 2'h1
`define EMP_ZX_ALL 2'h2
// Metering mode encodings of the two select pins.
`define EMP_MM_LARGER 2'h0
`define EMP_MM_FIXED_L 2'h1
`define EMP_MM_SUM 2'h2
`define EMP_MM_FLEX 2'h3
// Zero-crossing output pulse width in nanoseconds and in clock cycles.
`define EMP_ZX_PULSE_NS 5000
`define EMP_CLK_NS 10
`define EMP_ZX_PULSE_CYC (`EMP_ZX_PULSE_NS / `EMP_CLK_NS)
`endif

// ### emp_pins.v
// Operation
// - Serial input sampled on serial clock rising edge.
// - Read data shifted out on falling edge.
// - Three-wire frames are exactly 24 clock cycles.
// - Interrupt follows any set system status bit.
// - Select pins pick larger, fixed, summing modes.
// - Select 11 uses line select bit.
// - Zero-crossing output with selectable edge polarity.
// - Warning on calibration error or voltage sag.
// - Active and reactive energy pulse outputs.
// - No-load states suppress their energy pulses.
// - Active-low reset pin holds all logic.
`include "emp_map.vh"
module emp_pins #(
    parameter FRAME_BITS = `EMP_FRAME_BITS
) (
    input wire CLK_SYS,
    input wire RST_N,
    input wire THREE_WIRE,
    input wire CS_N,
    input wire SCLK,
    input wire SDI,
    output reg SDO,
    output reg SDO_OE_N,
    input wire MODE_SELECT_HI,
    input wire MODE_SELECT_LO,
    input wire [15:0] STATUS_BITS,
    input wire CAL_ERROR,
    input wire VOLTAGE_SAG,
    input wire VOLT_SIGN,
    input wire L_ACTIVE_PULSE,
    input wire N_ACTIVE_PULSE,
    input wire L_REACTIVE_PULSE,
    input wire N_REACTIVE_PULSE,
    input wire LARGER_IS_N,
    input wire ACTIVE_NO_LOAD,
    input wire REACTIVE_NO_LOAD,
    input wire [15:0] RD_DATA,
    output reg [6:0] REG_ADDR,
    output reg REG_RD,
    output reg REG_WR,
    output reg [15:0] REG_WDATA,
    output reg [15:0] METERING_MODE_REG,
    output reg [1:0] MODE_APPLIED,
    output reg IRQ,
    output reg FATAL_WARNING_OUT,
    output reg ZERO_CROSS_OUT,
    output reg ACTIVE_PULSE_OUT,
    output reg REACTIVE_PULSE_OUT
);
    // Reset release pipeline; all logic below uses rst_n.
    reg [1:0] rst_pipe;
    wire rst_n = rst_pipe[1];

    // The reset pin clears everything asynchronously and is released in sync.
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    // Every pin from outside the clock domain passes two flip-flops first.
    wire cs_s, sclk_s, sdi_s, mhi_s, mlo_s, sign_s;
    emp_sync u_cs (.clk(CLK_SYS), .rst_n(rst_n), .din(~CS_N), .dout(cs_s));
    emp_sync u_sclk (.clk(CLK_SYS), .rst_n(rst_n), .din(SCLK), .dout(sclk_s));
    emp_sync u_sdi (.clk(CLK_SYS), .rst_n(rst_n), .din(SDI), .dout(sdi_s));
    emp_sync u_mhi (.clk(CLK_SYS), .rst_n(rst_n), .din(MODE_SELECT_HI), .dout(mhi_s));
    emp_sync u_mlo (.clk(CLK_SYS), .rst_n(rst_n), .din(MODE_SELECT_LO), .dout(mlo_s));
    emp_sync u_sgn (.clk(CLK_SYS), .rst_n(rst_n), .din(VOLT_SIGN), .dout(sign_s));

    // Previous samples for edge detection, taken from synchronised copies only.
    // SCLK is oversampled, so each of its phases must last several system clocks.
    reg sclk_d, cs_d, sign_d;
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    // THREE_WIRE is a strap from logic on this clock, so it is read unsynchronised.
    // Select counts as active when held low, or always in three-wire mode.
    wire sel = THREE_WIRE | cs_s;
    wire sel_start = cs_s & ~cs_d & ~THREE_WIRE;

    // Frame state: bit counter, shift registers and the read flag.
    reg [4:0] bit_cnt;
    reg [23:0] shift_in;
    reg [15:0] shift_out;
    reg is_read;
    reg in_frame;
    wire [23:0] next_shift = {shift_in[22:0], sdi_s};
    // The frame length follows the parameter; the counter holds up to 31.
    wire last_bit = (bit_cnt == FRAME_BITS - 1);

    // Serial engine: sample on rising, shift on falling, frame by count.
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            cs_d <= 1'b0;
            bit_cnt <= 5'h00;
            shift_in <= 24'h000000;
            shift_out <= 16'h0000;
            is_read <= 1'b0;
            in_frame <= 1'b0;
            REG_ADDR <= 7'h00;
            REG_RD <= 1'b0;
            REG_WR <= 1'b0;
            REG_WDATA <= 16'h0000;
            SDO <= 1'b0;
            SDO_OE_N <= 1'b1;
            // The mode register restarts with every field at its default.
            METERING_MODE_REG <= `EMP_MODE_RESET;
        end else begin
            sclk_d <= sclk_s;
            cs_d <= cs_s;
            REG_RD <= 1'b0;
            REG_WR <= 1'b0;
            if (!sel || sel_start) begin
                // Deselect or a fresh frame restarts the count and frees the line.
                bit_cnt <= 5'h00;
                in_frame <= 1'b0;
                SDO_OE_N <= 1'b1;
            end else if (sclk_rise) begin
                // Capture one bit per rising serial edge.
                shift_in <= next_shift;
                in_frame <= ~last_bit;
                if (bit_cnt == 5'h00) begin
                    // The first bit of a frame decides between read and write.
                    is_read <= sdi_s;
                end
                if (bit_cnt == `EMP_ADDR_BITS) begin
                    // Address complete; fetch read data in time for bit 8.
                    REG_ADDR <= next_shift[6:0];
                    REG_RD <= shift_in[6];
                end
                if (last_bit) begin
                    bit_cnt <= 5'h00;
                    if (!is_read) begin
                        REG_WR <= 1'b1;
                        REG_WDATA <= next_shift[15:0];
                        if (REG_ADDR == `EMP_ADDR_MODE) begin
                            METERING_MODE_REG <= next_shift[15:0];
                        end
                    end
                end else begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
            end else if (sclk_fall && is_read && bit_cnt >= `EMP_ADDR_BITS + 1) begin
                // Drive read data MSB first on each falling serial edge.
                if (bit_cnt == `EMP_ADDR_BITS + 1) begin
                    SDO <= (REG_ADDR == `EMP_ADDR_MODE) ? METERING_MODE_REG[15] : RD_DATA[15];
                    shift_out <= (REG_ADDR == `EMP_ADDR_MODE) ?
                        {METERING_MODE_REG[14:0], 1'b0} : {RD_DATA[14:0], 1'b0};
                end else begin
                    SDO <= shift_out[15];
                    shift_out <= {shift_out[14:0], 1'b0};
                end
                SDO_OE_N <= 1'b0;
            end else if (sclk_fall && !in_frame) begin
                // After the last bit the line is released again.
                SDO_OE_N <= 1'b1;
            end
        end
    end

    // Mode pins are taken only while no frame is in progress.
    wire [1:0] pins = {mhi_s, mlo_s};
    wire [1:0] line_sel = (MODE_APPLIED == `EMP_MM_LARGER) ? {1'b0, LARGER_IS_N} :
                          (MODE_APPLIED == `EMP_MM_FIXED_L) ? 2'h0 :
                          (MODE_APPLIED == `EMP_MM_SUM) ? 2'h2 :
                          {1'b0, METERING_MODE_REG[`EMP_MODE_LINE_SELECT_BIT_BIT]};
    // Line chosen per mode: bit 1 means sum, bit 0 means N line.
    wire act_src = line_sel[1] ? (L_ACTIVE_PULSE | N_ACTIVE_PULSE) :
                   (line_sel[0] ? N_ACTIVE_PULSE : L_ACTIVE_PULSE);
    wire react_src = line_sel[1] ? (L_REACTIVE_PULSE | N_REACTIVE_PULSE) :
                     (line_sel[0] ? N_REACTIVE_PULSE : L_REACTIVE_PULSE);
    // The summing mode ORs pulses; coincident pulses from both lines merge, a known limit.

    // Zero-crossing polarity decode from the mode register field.
    wire [1:0] zx_sel = METERING_MODE_REG[`EMP_MODE_ZX_MSB:`EMP_MODE_ZX_LSB];
    wire pos_x = ~sign_s & sign_d;
    wire neg_x = sign_s & ~sign_d;
    wire zx_hit = (zx_sel == `EMP_ZX_POS) ? pos_x :
                  (zx_sel == `EMP_ZX_NEG) ? neg_x : (pos_x | neg_x);
    reg [15:0] zx_cnt;
    // Pulse length in cycles; the counter keeps only its low 16 bits.
    localparam [31:0] ZX_PULSE_FULL = `EMP_ZX_PULSE_CYC;

    // Output pins: every one is registered so glitches never reach the package.
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            MODE_APPLIED <= `EMP_MM_LARGER;
            IRQ <= 1'b0;
            FATAL_WARNING_OUT <= 1'b0;
            ZERO_CROSS_OUT <= 1'b0;
            ACTIVE_PULSE_OUT <= 1'b0;
            REACTIVE_PULSE_OUT <= 1'b0;
            sign_d <= 1'b0;
            zx_cnt <= 16'h0000;
        end else begin
            // Sign history resets to the synchroniser's value, so reset fakes no crossing.
            sign_d <= sign_s;
            if (!in_frame) begin
                MODE_APPLIED <= pins;
            end
            IRQ <= |STATUS_BITS;
            FATAL_WARNING_OUT <= CAL_ERROR | VOLTAGE_SAG;
            ACTIVE_PULSE_OUT <= act_src & ~ACTIVE_NO_LOAD;
            REACTIVE_PULSE_OUT <= react_src & ~REACTIVE_NO_LOAD;
            if (zx_hit) begin
                // A crossing restarts the output pulse.
                zx_cnt <= ZX_PULSE_FULL[15:0];
                ZERO_CROSS_OUT <= 1'b1;
            end else if (zx_cnt != 16'h0000) begin
                zx_cnt <= zx_cnt - 16'h0001;
                ZERO_CROSS_OUT <= (zx_cnt != 16'h0001);
            end else begin
                ZERO_CROSS_OUT <= 1'b0;
            end
        end
    end
endmodule

// ### emp_pins_checker.sv
module emp_pins_checker #(
    parameter FRAME_BITS = 24
) (
    input wire CLK_SYS,
    input wire RST_N,
    input wire THREE_WIRE,
    input wire CS_N,
    input wire SDO_OE_N,
    input wire MODE_SELECT_HI,
    input wire MODE_SELECT_LO,
    input wire CAL_ERROR,
    input wire VOLTAGE_SAG,
    input wire L_ACTIVE_PULSE,
    input wire ACTIVE_NO_LOAD,
    input wire REACTIVE_NO_LOAD,
    input wire REG_RD,
    input wire REG_WR,
    input wire IRQ,
    input wire FATAL_WARNING_OUT,
    input wire ZERO_CROSS_OUT,
    input wire ACTIVE_PULSE_OUT,
    input wire REACTIVE_PULSE_OUT,
    input wire [15:0] STATUS_BITS,
    input wire [15:0] REG_WDATA,
    input wire [15:0] METERING_MODE_REG,
    input wire [6:0] REG_ADDR,
    input wire [1:0] MODE_APPLIED
);
    timeunit 1ns;
    timeprecision 1ps;
    // Edges since reset, so that checks skip the reset synchroniser fill.
    reg [2:0] up;
    wire rdy = up == 3'h7;
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) up <= 3'h0;
        else if (!rdy) up <= up + 3'h1;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    AST_IRQ: assert property (rdy |=> IRQ == (|$past(STATUS_BITS))) else $error("irq");
    AST_WARN: assert property (rdy |=> FATAL_WARNING_OUT == $past(CAL_ERROR || VOLTAGE_SAG))
        else $error("warn");
    AST_RELEASE: assert property ((!THREE_WIRE && CS_N)[*5] |-> SDO_OE_N)
        else $error("sdo not released");
    AST_MODE: assert property ((rdy && CS_N && !THREE_WIRE
        && $stable({MODE_SELECT_HI, MODE_SELECT_LO}))[*6]
        |-> MODE_APPLIED == {MODE_SELECT_HI, MODE_SELECT_LO}) else $error("mode");
    AST_FIXED: assert property ((rdy && !ACTIVE_NO_LOAD && MODE_APPLIED == 2'h1)[*2]
        |=> ACTIVE_PULSE_OUT == $past(L_ACTIVE_PULSE)) else $error("fixed line");
    AST_ANL: assert property (ACTIVE_NO_LOAD[*3] |-> !ACTIVE_PULSE_OUT) else $error("anl");
    AST_RNL: assert property (REACTIVE_NO_LOAD[*3] |-> !REACTIVE_PULSE_OUT)
        else $error("rnl");
    AST_MODEREG: assert property (REG_WR && REG_ADDR == 7'h2B
        |=> METERING_MODE_REG == $past(REG_WDATA)) else $error("mode reg");
    AST_ZXW: assert property ($rose(ZERO_CROSS_OUT) |-> ZERO_CROSS_OUT[*8])
        else $error("zx width");
    COV_RD: cover property (REG_RD);
    COV_WR: cover property (REG_WR);
    COV_ZX: cover property ($rose(ZERO_CROSS_OUT));
endmodule
bind emp_pins emp_pins_checker #(
    .FRAME_BITS(FRAME_BITS)
) u_chk (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .THREE_WIRE(THREE_WIRE),
    .CS_N(CS_N),
    .SDO_OE_N(SDO_OE_N),
    .MODE_SELECT_HI(MODE_SELECT_HI),
    .MODE_SELECT_LO(MODE_SELECT_LO),
    .CAL_ERROR(CAL_ERROR),
    .VOLTAGE_SAG(VOLTAGE_SAG),
    .L_ACTIVE_PULSE(L_ACTIVE_PULSE),
    .ACTIVE_NO_LOAD(ACTIVE_NO_LOAD),
    .REACTIVE_NO_LOAD(REACTIVE_NO_LOAD),
    .REG_RD(REG_RD),
    .REG_WR(REG_WR),
    .IRQ(IRQ),
    .FATAL_WARNING_OUT(FATAL_WARNING_OUT),
    .ZERO_CROSS_OUT(ZERO_CROSS_OUT),
    .ACTIVE_PULSE_OUT(ACTIVE_PULSE_OUT),
    .REACTIVE_PULSE_OUT(REACTIVE_PULSE_OUT),
    .STATUS_BITS(STATUS_BITS),
    .REG_WDATA(REG_WDATA),
    .METERING_MODE_REG(METERING_MODE_REG),
    .REG_ADDR(REG_ADDR),
    .MODE_APPLIED(MODE_APPLIED)
);

// ### emp_sync.v
// Two-stage synchroniser for one level coming from outside the clock domain.
module emp_sync (
    input wire clk,
    input wire rst_n,
    input wire din,
    output reg dout
);
    // First stage; read only by the second stage.
    reg meta;

    // Both stages clear to zero under reset.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ### tb.sv
`include "emp_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS = 1'h0, RST_N = 1'h0, THREE_WIRE = 1'h0, MODE_SELECT_HI = 1'h0;
    logic MODE_SELECT_LO = 1'h0, CAL_ERROR = 1'h0, VOLTAGE_SAG = 1'h0, VOLT_SIGN = 1'h0;
    logic L_ACTIVE_PULSE = 1'h0, N_ACTIVE_PULSE = 1'h0, L_REACTIVE_PULSE = 1'h0;
    logic N_REACTIVE_PULSE = 1'h0, LARGER_IS_N = 1'h1, ACTIVE_NO_LOAD = 1'h0;
    logic REACTIVE_NO_LOAD = 1'h0, CS_N, SCLK, SDI, SDO, SDO_OE_N, REG_RD, REG_WR, IRQ;
    logic FATAL_WARNING_OUT, ZERO_CROSS_OUT, ACTIVE_PULSE_OUT, REACTIVE_PULSE_OUT;
    logic [15:0] STATUS_BITS = 16'h0, RD_DATA = 16'h0, REG_WDATA, METERING_MODE_REG, rx, d;
    logic [6:0] REG_ADDR;
    logic [1:0] MODE_APPLIED;
    logic [22:0] wq[$];
    logic [6:0] rq[$];
    int error_cnt = 0, tests_run = 0;
    emp_pins #(.FRAME_BITS(24)) i_dut (.*);
    emp_host u_host (.clk(CLK_SYS), .sdo(SDO), .sdo_oe_n(SDO_OE_N), .cs_n(CS_N),
        .sclk(SCLK), .sdi(SDI));
    initial forever #5 CLK_SYS = ~CLK_SYS;
    task automatic cmp(input string n, input logic [22:0] e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    // Whole write frames, and read frames of 8 or more bits, leave a note for the strobe monitor.
    task automatic fr(input logic tw, rw, input logic [6:0] a, input logic [15:0] v,
        input int h, c);
        if (!rw && c == 24) wq.push_back({a, v});
        if (rw && c >= 8) rq.push_back(a);
        u_host.xfer(tw, {rw, a, v}, h, c, rx);
    endtask
    // Sampled mid-cycle so the registered strobe has settled.
    always @(negedge CLK_SYS) begin
        if (REG_WR === 1'h1) begin
            cmp("wr", wq.size() ? wq.pop_front() : 23'hx, {REG_ADDR, REG_WDATA});
        end
        if (REG_RD === 1'h1) begin
            cmp("rdaddr", rq.size() ? rq.pop_front() : 23'hx, REG_ADDR);
        end
    end
    initial begin
        #200us;
        error_cnt++;
        stop_test();
    end
    initial begin
        void'($urandom(12564));
        cyc(10);
        RST_N = 1'h1;
        cyc(8);
        d = 16'($urandom);
        d[3:2] = 2'h2;
        fr(0, 0, 7'h2B, d, 4, 24);
        cyc(4);
        cmp("modereg", d, METERING_MODE_REG);
        fr(0, 1, 7'h2B, 16'h0, 6, 24);
        cmp("rd", d, rx);
        RD_DATA = 16'($urandom);
        fr(0, 1, 7'h01, 16'h0, 4, 12);
        cyc(5);
        cmp("oe", 1, SDO_OE_N);
        fr(0, 0, 7'h05, 16'hFFFF, 4, 20);
        fr(0, 1, 7'h01, 16'h0, 4, 24);
        cmp("rd", RD_DATA, rx);
        {L_ACTIVE_PULSE, L_REACTIVE_PULSE} = 2'h3;
        for (int m = 0; m < 4; m++) begin
            {MODE_SELECT_HI, MODE_SELECT_LO} = m[1:0];
            cyc(8);
            cmp("mode", m[1:0], MODE_APPLIED);
            cmp("cf", {2{m == 1 || m == 2 || (m == 3 && !d[`EMP_MODE_LINE_SELECT_BIT_BIT])}},
                {ACTIVE_PULSE_OUT, REACTIVE_PULSE_OUT});
        end
        {ACTIVE_NO_LOAD, REACTIVE_NO_LOAD} = 2'h3;
        cyc(4);
        cmp("noload", 0, {ACTIVE_PULSE_OUT, REACTIVE_PULSE_OUT});
        for (int w = 0; w < 4; w++) begin
            {CAL_ERROR, VOLTAGE_SAG} = w[1:0];
            STATUS_BITS = w[0] ? 16'h1 << $urandom_range(15) : 16'h0;
            cyc(3);
            cmp("warn", w != 0, FATAL_WARNING_OUT);
            cmp("irq", w[0], IRQ);
        end
        VOLT_SIGN = 1'h1;
        cyc(600);
        VOLT_SIGN = 1'h0;
        cyc(10);
        cmp("zx", 1, ZERO_CROSS_OUT);
        cyc(520);
        cmp("zx", 0, ZERO_CROSS_OUT);
        d[`EMP_MODE_ZX_MSB:`EMP_MODE_ZX_LSB] = `EMP_ZX_POS;
        fr(0, 0, 7'h2B, d, 4, 24);
        VOLT_SIGN = 1'h1;
        cyc(10);
        cmp("zxneg", 0, ZERO_CROSS_OUT);
        VOLT_SIGN = 1'h0;
        cyc(10);
        cmp("zxpos", 1, ZERO_CROSS_OUT);
        cyc(520);
        RST_N = 1'h0;
        cyc(2);
        cmp("rst", {`EMP_MODE_RESET, 1'h1, 1'h0, 1'h0, `EMP_MM_LARGER},
            {METERING_MODE_REG, SDO_OE_N, IRQ, FATAL_WARNING_OUT, MODE_APPLIED});
        RST_N = 1'h1;
        cyc(8);
        cmp("irq", 1, IRQ);
        THREE_WIRE = 1'h1;
        fr(1, 0, 7'h7F, 16'($urandom), 4, 24);
        fr(1, 1, 7'h01, 16'h0, 4, 24);
        cmp("rd3", RD_DATA, rx);
        cyc(20);
        cmp("pending", 0, 23'(wq.size() + rq.size()));
        stop_test();
    end
endmodule
